/* rstc_top.sv */
// ranging time counter with ahb-lite register access
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - chain runs full 2048 us terminal count
// - enable arms the dead-time reply gate
// - clear raised with enable, held whole count
// - clear low holds stages and latches zero
// - overflow interrupt pulse at 2048 us, then every 4096 us as the 12-bit chain wraps
// - one count per microsecond, crystal divided four
// - count tick reaches every stage, never gated
// - each stage is 4-bit, sixteen states
// - wrap flag high only on fifteenth count
// - stage wrap flags chain into next gate
// - stage counts only while gate is high
// - plain binary, lsb bit zero, from zero
// - reply samples running count on the fly
// - reply never stops counters, only latches
// - latch strobe fires 60 us dead time
// - interrupt from stage three most significant bit
module rstc_top (
  // ahb-lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // reply decoder
  input wire logic reply_decoded,
  // ranging outputs
  output logic range_overflow_irq,
  output logic valid_decode_n,
  output logic [rstc_pkg::RSTC_COUNT_W-1:0] live_count,
  output logic [rstc_pkg::RSTC_COUNT_W-1:0] captured_count
);
  import rstc_pkg::*;

  // ---------------- bus side ----------------
  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_q;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic ctrl_wr;

  // control lines as software drives them
  logic search_enable;
  logic clear_n;

  // ---------------- counting side ----------------
  logic [RSTC_TICK_W-1:0] div_q;
  logic [RSTC_TICK_W-1:0] div_d;
  logic count_tick;
  logic [RSTC_STAGES:0] gate_chain;
  logic [RSTC_COUNT_W-1:0] count_bits;
  logic [RSTC_COUNT_W-1:0] live_q;
  logic ovf_bit;
  logic ovf_q;
  logic irq_q;
  logic ovf_seen_q;

  // ---------------- reply side ----------------
  logic reply_q;
  logic reply_rise;
  logic reply_take;
  logic [RSTC_DEAD_W-1:0] dead_q;
  logic [RSTC_DEAD_W-1:0] dead_d;
  logic dead_busy;
  logic [RSTC_COUNT_W-1:0] capt_q;
  logic capt_seen_q;
  logic vdn_q;

  // zero wait states; every access answers okay
  assign hreadyout = 1'b1;
  assign hresp = RSTC_HRESP_OKAY;
  assign hrdata = hrdata_q;

  // only whole aligned words are decoded
  assign addr_ok = (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'b00)
                   & (hsize == 3'b010);
  assign rd_take = hsel & hready & (htrans == RSTC_HTRANS_NONSEQ) & ~hwrite;
  assign wr_take = hsel & hready & (htrans == RSTC_HTRANS_NONSEQ) & hwrite
                   & addr_ok;

  // read data chosen in the address phase, registered for the data phase
  assign rd_mux =
      !addr_ok ? 32'h0000_0000 :
      (haddr[7:0] == RSTC_CTRL_OFS) ? {30'h0000_0000, ctrl_q} :
      (haddr[7:0] == RSTC_COUNT_OFS) ? {20'h0_0000, live_q} :
      (haddr[7:0] == RSTC_CAPT_OFS) ? {20'h0_0000, capt_q} :
      (haddr[7:0] == RSTC_STAT_OFS) ?
        {29'h0000_0000, capt_seen_q, ovf_seen_q, ~vdn_q} :
      32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_q <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_take;
      wr_ofs_q <= haddr[7:0];
    end
  end

  // write lands in the data phase, when hwdata is valid
  assign ctrl_wr = wr_pend_q & (wr_ofs_q == RSTC_CTRL_OFS);
  assign ctrl_d = ctrl_wr ?
      {hwdata[RSTC_CTRL_CLEAR_BIT], hwdata[RSTC_CTRL_ENABLE_BIT]} : ctrl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= RSTC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // the controller raises both together and holds them for the count
  assign search_enable = ctrl_q[RSTC_CTRL_ENABLE_BIT];
  assign clear_n = ctrl_q[RSTC_CTRL_CLEAR_BIT];

  // ---------------- 1 us count tick ----------------
  // strobe instead of a derived clock keeps one domain
  assign div_d = (div_q == RSTC_TICK_W'(RSTC_TICK_CYC - 1)) ?
      '0 : RSTC_TICK_W'(div_q + 1'b1);
  assign count_tick = (div_q == RSTC_TICK_W'(RSTC_TICK_CYC - 1));

  // free running: counting is steered only by enable, clear and the stage gates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ---------------- counter chain ----------------
  assign gate_chain[0] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < RSTC_STAGES; gi++) begin : g_stage
      rstc_stage #(
        .WIDTH(RSTC_STAGE_W)
      ) u_stage (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear_n(clear_n),
        .count_tick(count_tick),
        .count_en(search_enable),
        .cascade_count_gate(gate_chain[gi]),
        .stage_bits(count_bits[gi*RSTC_STAGE_W +: RSTC_STAGE_W]),
        .stage_wrap_flag(gate_chain[gi+1])
      );
    end
  endgenerate

  // top bit of stage three rises after 2048 ticks
  assign ovf_bit = count_bits[RSTC_OVF_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q <= '0;
      ovf_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      live_q <= count_bits;
      ovf_q <= ovf_bit;
      irq_q <= ovf_bit & ~ovf_q;
    end
  end

  // sticky overflow seen; clear line drops it, a new wrap wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_seen_q <= 1'b0;
    end else if (ovf_bit & ~ovf_q) begin
      ovf_seen_q <= 1'b1;
    end else if (!clear_n) begin
      ovf_seen_q <= 1'b0;
    end
  end

  assign range_overflow_irq = irq_q;
  assign live_count = live_q;

  // ---------------- reply capture ----------------
  assign reply_rise = reply_decoded & ~reply_q;
  assign dead_busy = (dead_q != '0);
  // replies count only inside an armed window and outside dead time
  assign reply_take = reply_rise & search_enable & clear_n & ~dead_busy;

  assign dead_d =
      !clear_n ? '0 :
      reply_take ? RSTC_DEAD_W'(RSTC_DEAD_CYC) :
      dead_busy ? RSTC_DEAD_W'(dead_q - 1'b1) : dead_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reply_q <= 1'b0;
      dead_q <= '0;
    end else begin
      reply_q <= reply_decoded;
      dead_q <= dead_d;
    end
  end

  // sample only; the chain keeps running to its terminal count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_q <= '0;
      capt_seen_q <= 1'b0;
    end else if (!clear_n) begin
      capt_q <= '0;
      capt_seen_q <= 1'b0;
    end else if (reply_take) begin
      capt_q <= count_bits;
      capt_seen_q <= 1'b1;
    end
  end

  // valid decode is low for the dead-time window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdn_q <= 1'b1;
    end else begin
      vdn_q <= ~(dead_d != '0);
    end
  end

  assign valid_decode_n = vdn_q;
  assign captured_count = capt_q;

endmodule

/* rstc_pkg.sv */
// shared constants for the ranging time counter
package rstc_pkg;

  // register byte offsets
  localparam logic [7:0] RSTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] RSTC_COUNT_OFS = 8'h04;
  localparam logic [7:0] RSTC_CAPT_OFS = 8'h08;
  localparam logic [7:0] RSTC_STAT_OFS = 8'h0C;

  // control fields
  localparam int RSTC_CTRL_ENABLE_BIT = 0;
  localparam int RSTC_CTRL_CLEAR_BIT = 1;
  localparam logic [1:0] RSTC_CTRL_RESET = 2'h0;

  // status fields
  localparam int RSTC_STAT_VALID_BIT = 0;
  localparam int RSTC_STAT_OVF_BIT = 1;
  localparam int RSTC_STAT_CAPT_BIT = 2;

  // counter chain shape
  localparam int RSTC_STAGE_W = 4;
  localparam int RSTC_STAGES = 3;
  localparam int RSTC_COUNT_W = RSTC_STAGE_W * RSTC_STAGES;
  localparam int RSTC_OVF_BIT = 11;
  localparam logic [RSTC_STAGE_W-1:0] RSTC_STAGE_LAST = 4'hF;
  localparam logic [RSTC_STAGE_W-1:0] RSTC_STAGE_RESET = 4'h0;

  // timing
  localparam int RSTC_HCLK_HZ = 20_000_000;
  localparam int RSTC_CRYSTAL_HZ = 4_000_000;
  localparam int RSTC_CRYSTAL_DIV = 4;
  localparam int RSTC_TICK_HZ = RSTC_CRYSTAL_HZ / RSTC_CRYSTAL_DIV;
  localparam int RSTC_TICK_CYC = RSTC_HCLK_HZ / RSTC_TICK_HZ;
  localparam int RSTC_TICK_W = $clog2(RSTC_TICK_CYC);
  localparam int RSTC_TERMINAL_US = 2048;
  localparam int RSTC_DEAD_US = 60;
  localparam int RSTC_DEAD_CYC = (RSTC_DEAD_US * RSTC_HCLK_HZ) / 1_000_000;
  localparam int RSTC_DEAD_W = $clog2(RSTC_DEAD_CYC + 1);

  // ahb encodings
  localparam logic [1:0] RSTC_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] RSTC_HRESP_OKAY = 2'b00;

endpackage

/* rstc_stage.sv */
// one 4-bit binary stage of the ranging counter chain
`timescale 1ns/1ps
module rstc_stage #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // controls
  input wire logic clear_n,
  input wire logic count_tick,
  input wire logic count_en,
  input wire logic cascade_count_gate,
  // outputs
  output logic [WIDTH-1:0] stage_bits,
  output logic stage_wrap_flag
);
  import rstc_pkg::*;

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic step;

  // gate decides counting, the tick itself is never gated
  assign step = count_tick & count_en & cascade_count_gate;
  assign cnt_d = step ? WIDTH'(cnt_q + 1'b1) : cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (!clear_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign stage_bits = cnt_q;
  // fully decoded: only at the last state and while gated in
  assign stage_wrap_flag = (cnt_q == {WIDTH{1'b1}}) & cascade_count_gate;

endmodule

/* rstc_top_chk.sv */
// concurrent checks on the ranging counter ports
`timescale 1ns/1ps
module rstc_top_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched outputs
  input wire logic range_overflow_irq,
  input wire logic valid_decode_n,
  input wire logic [rstc_pkg::RSTC_COUNT_W-1:0] live_count,
  input wire logic [rstc_pkg::RSTC_COUNT_W-1:0] captured_count
);
  import rstc_pkg::*;
  logic [10:0] dead_q;
  int gap_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // dead time length and tick spacing are too long for repetition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dead_q <= 11'h000;
      gap_q <= 0;
    end else begin
      dead_q <= valid_decode_n ? 11'h000 : dead_q + 11'h001;
      gap_q <= $changed(live_count) ? 0 : gap_q + 1;
    end
  end
  a_irq_pulse: assert property (range_overflow_irq |=> !range_overflow_irq)
    else $error("overflow pulse longer than one cycle");
  a_irq_source: assert property ($rose(live_count[RSTC_OVF_BIT])
    |-> ##[0:2] range_overflow_irq)
    else $error("overflow pulse missing after top bit set");
  a_irq_cause: assert property (range_overflow_irq |-> live_count[RSTC_OVF_BIT])
    else $error("overflow pulse without top bit");
  a_dead_len: assert property ($rose(valid_decode_n) |-> $past(dead_q) == 11'h4AF)
    else $error("dead time length wrong");
  a_capt_live: assert property ($fell(valid_decode_n) |-> captured_count == live_count)
    else $error("capture differs from running count");
  a_capt_hold: assert property (!valid_decode_n && !$past(valid_decode_n)
    |-> $stable(captured_count) || captured_count == 12'h000)
    else $error("capture changed during dead time");
  a_count_step: assert property ($changed(live_count)
    |-> live_count == $past(live_count) + 12'h001 || live_count == 12'h000)
    else $error("count not binary step");
  a_tick_gap: assert property ($changed(live_count) && live_count > 12'h001
    |-> (gap_q % RSTC_TICK_CYC) == RSTC_TICK_CYC - 1)
    else $error("count step spacing wrong");
endmodule
bind rstc_top rstc_top_chk u_rstc_top_chk (.hclk(hclk), .hresetn(hresetn),
  .range_overflow_irq(range_overflow_irq), .valid_decode_n(valid_decode_n),
  .live_count(live_count), .captured_count(captured_count));

/* rstc_reply_src.sv */
// reply decoder stand-in making decoded reply pulses
`timescale 1ns/1ps
module rstc_reply_src (
  // clock
  input wire logic hclk,
  // request from the bench
  input wire logic fire,
  // decoded reply
  output logic reply_decoded = 1'b0
);
  // one pulse per request, low in between so every reply is a fresh edge
  always @(posedge hclk) begin
    reply_decoded <= fire;
  end
endmodule

/* test_range_search_track_counter.sv */
// self-checking bench for the ranging time counter
`timescale 1ns/1ps
module test_range_search_track_counter;
  import rstc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic fire = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [1:0] hresp;
  logic hready, hreadyout, reply_decoded, range_overflow_irq, valid_decode_n;
  logic [31:0] hrdata, r;
  logic [RSTC_COUNT_W-1:0] live_count, captured_count;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int kf, irq_k, irq_n;
  assign hready = hreadyout;
  rstc_top u_rstc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reply_decoded(reply_decoded),
    .range_overflow_irq(range_overflow_irq), .valid_decode_n(valid_decode_n),
    .live_count(live_count), .captured_count(captured_count));
  rstc_reply_src u_rstc_reply_src (.hclk(hclk), .fire(fire), .reply_decoded(reply_decoded));
  initial begin
    forever #25 hclk = ~hclk;
  end
  task end_sim;
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // full run is about 43k cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= RSTC_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    cmp(32'(hresp), 32'(RSTC_HRESP_OKAY));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, r);
    cmp(r, e);
  endtask
  initial begin
    kf = 200 + $urandom(28) % 400;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0000_0000);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF, r);
    rd(8'h10, 32'h0000_0000);
    // byte-sized write is refused like an unmapped one
    hsize <= 3'b000;
    bus(1'b1, RSTC_CTRL_OFS, 32'h0000_0003, r);
    hsize <= 3'b010;
    rd(RSTC_CTRL_OFS, 32'h0000_0000);
    // released but not enabled: frozen, replies refused
    bus(1'b1, RSTC_CTRL_OFS, 32'h0000_0002, r);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (60) @(posedge hclk);
    rd(RSTC_COUNT_OFS, 32'h0000_0000);
    rd(RSTC_CAPT_OFS, 32'h0000_0000);
    // enabled while held clear
    bus(1'b1, RSTC_CTRL_OFS, 32'h0000_0001, r);
    repeat (60) @(posedge hclk);
    rd(RSTC_COUNT_OFS, 32'h0000_0000);
    // pulse pair and lead-in have no pins; the count starts here
    bus(1'b1, RSTC_CTRL_OFS, 32'h0000_0003, r);
    while (live_count !== 12'h001) begin
      @(posedge hclk);
      #1;
    end
    irq_n = 0;
    for (int k = 1; k < 41500; k++) begin
      @(posedge hclk);
      fire <= (k == kf || k == kf + 100 || k == kf + 1400);
      #1;
      cmp(32'(live_count), 32'(1 + k / RSTC_TICK_CYC));
      if (range_overflow_irq === 1'b1) begin
        irq_n++;
        irq_k = k;
      end
      if (k == kf + 2 || k == kf + 102) cmp(32'(captured_count), 32'(1 + (kf + 2) / 20));
      if (k == kf + 1402) cmp(32'(captured_count), 32'(1 + (kf + 1402) / 20));
      if (k == kf + 1201 || k == kf + 1202) cmp(32'(valid_decode_n), 32'(k - kf - 1201));
    end
    cmp(32'(irq_n), 32'h0000_0001);
    cmp(32'(irq_k >= 40940 && irq_k <= 40942), 32'h0000_0001);
    rd(RSTC_STAT_OFS, 32'h0000_0006);
    rd(RSTC_CAPT_OFS, 32'(1 + (kf + 1402) / 20));
    rd(RSTC_CTRL_OFS, 32'h0000_0003);
    // bench plays one terminal count of the cycle only
    // dropping both lines zeroes everything; chain and live copy lag two edges
    bus(1'b1, RSTC_CTRL_OFS, 32'h0000_0000, r);
    repeat (2) @(posedge hclk);
    rd(RSTC_COUNT_OFS, 32'h0000_0000);
    rd(RSTC_CAPT_OFS, 32'h0000_0000);
    rd(RSTC_STAT_OFS, 32'h0000_0000);
    // off gap, then a fresh count starts from zero
    repeat (1800) @(posedge hclk);
    bus(1'b1, RSTC_CTRL_OFS, 32'h0000_0003, r);
    while (live_count !== 12'h001) begin
      @(posedge hclk);
      #1;
    end
    repeat (40) @(posedge hclk);
    #1;
    cmp(32'(live_count), 32'h0000_0003);
    end_sim();
  end
endmodule
